// *** rtl/tsiu_pkg.sv ***
package tsiu_pkg;

  // ----------------------------------------------------------------
  // register map (index times four gives the byte address)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h00b;
  localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 12'h010;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 12'h011;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX[ADDR_W-3:0], 2'b00};

  // ----------------------------------------------------------------
  // interrupt_control fields
  // ----------------------------------------------------------------
  localparam int unsigned MEN_BIT = 0;
  localparam int unsigned EEN_BIT = 1;
  localparam int unsigned TEN_BIT = 2;
  localparam int unsigned EFLAG_BIT = 4;
  localparam int unsigned TFLAG_BIT = 5;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // vectors and core stack
  // ----------------------------------------------------------------
  localparam logic [7:0] EXT_VECTOR = 8'h04;
  localparam logic [7:0] TMR_VECTOR = 8'h08;
  localparam int unsigned STACK_DEPTH = 4;

  // ----------------------------------------------------------------
  // event status / mask layout
  // ----------------------------------------------------------------
  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_EXT = 0;
  localparam int unsigned EVT_TMR = 1;
  localparam int unsigned EVT_CALL = 2;
  localparam int unsigned EVT_WAKE = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

endpackage

// *** rtl/tsiu_arb_if.sv ***
`timescale 1ns/10ps
interface tsiu_arb_if;
  logic ext_req;
  logic tmr_req;
  logic master_en;
  logic stack_full;
  logic phase;
  logic halted;
  logic grant;
  logic grant_ext;
  logic [7:0] vector;

  modport ctl (output ext_req, output tmr_req, output master_en, output stack_full, output phase,
               output halted, input grant, input grant_ext, input vector);
  modport arb (input ext_req, input tmr_req, input master_en, input stack_full, input phase,
               input halted, output grant, output grant_ext, output vector);
endinterface

// *** rtl/tsiu_fall_sync.sv ***
`timescale 1ns/10ps
module tsiu_fall_sync
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // asynchronous active-low pin
  input wire logic pin_n_i,
  // one-cycle pulse on a high-to-low transition
  output logic fall_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // pin idles high, so reset to high to avoid a false edge on release
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin_n_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign fall_o = prev_r & ~sync_r;

endmodule // tsiu_fall_sync

// *** rtl/tsiu_arbiter.sv ***
`timescale 1ns/10ps
module tsiu_arbiter
(
  tsiu_arb_if.arb a
);
  import tsiu_pkg::*;

  logic any_req;

  assign any_req = a.ext_req | a.tmr_req;
  // service only at a phase pulse, master on, stack room, core running
  assign a.grant = a.phase & a.master_en & ~a.stack_full & ~a.halted & any_req;
  // external source always outranks the timer
  assign a.grant_ext = a.ext_req;
  assign a.vector = a.ext_req ? EXT_VECTOR : TMR_VECTOR;

endmodule // tsiu_arbiter

// *** rtl/tsiu_top.sv ***
// Functional notes
// - external and timer interrupts wake from halt
// - service pushes only PC, branches to vector
// - falling external pin sets flag bit 4
// - external service calls 04H, clears flag, master
// - timer overflow sets flag bit 5
// - timer service calls 08H, clears flag, master
// - no further acknowledge until master re-enabled
// - return-from-interrupt sets master; plain return not
// - requests taken at next phase-two pulse
// - external outranks timer; master masks both
// - control bits: master 0, external 1, timer 2
// - bits 3, 6, 7 read zero
// - flag stays set until serviced or cleared
// - service needs master and source enable set
// - stack full withholds acknowledge
// - flag set at halt entry blocks wake
// - unserviceable wake resumes at next instruction
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module tsiu_top
#(
  parameter int unsigned STACK_LEVELS = tsiu_pkg::STACK_DEPTH
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic [tsiu_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt sources
  input wire logic ext_int_n_i,
  input wire logic tmr_ovf_i,
  // core sequencer
  input wire logic phase_two_pulse_i,
  input wire logic return_from_irq_i,
  input wire logic [2:0] stack_ptr_i,
  input wire logic halted_i,
  output logic call_o,
  output logic [7:0] call_vector_o,
  output logic wake_o,
  output logic wake_resume_next_o,
  // interrupt to host
  output logic irq_o
);
  import tsiu_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (STACK_LEVELS < 1 || STACK_LEVELS > 7)
  begin : g_bad_depth
    $error("STACK_LEVELS must be 1 to 7 for a 3-bit stack pointer");
  end

  localparam logic [2:0] STACK_FULL_LVL = 3'(STACK_LEVELS);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ext_fall;
  logic stack_full;
  logic take;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic call_r;
  logic [7:0] vec_r;
  logic halted_d_r;
  logic [1:0] wake_blk_r;
  logic [1:0] blk_now;
  logic halt_entry;
  logic ext_wake;
  logic tmr_wake;
  logic wake_ev;
  logic wake_serviceable;
  logic wake_r;
  logic resume_next_r;
  logic [EVT_W-1:0] evt_stat_r;
  logic [EVT_W-1:0] evt_mask_r;
  logic [EVT_W-1:0] evt_in;
  logic irq_r;
  logic acc_first;
  logic xfer_done;
  logic wr_en;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // ----------------------------------------------------------------
  // source capture and arbitration
  // ----------------------------------------------------------------
  tsiu_fall_sync u_ext_sync
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_n_i(ext_int_n_i),
    .fall_o(ext_fall)
  );

  // the core owns the stack; a pointer at the depth means no room left
  assign stack_full = (stack_ptr_i >= STACK_FULL_LVL);

  tsiu_arb_if arb ();

  assign arb.ext_req = ctrl_r[EFLAG_BIT] & ctrl_r[EEN_BIT];
  assign arb.tmr_req = ctrl_r[TFLAG_BIT] & ctrl_r[TEN_BIT];
  assign arb.master_en = ctrl_r[MEN_BIT];
  assign arb.stack_full = stack_full;
  assign arb.phase = phase_two_pulse_i;
  assign arb.halted = halted_i;

  tsiu_arbiter u_arb
  (
    .a(arb.arb)
  );

  assign take = arb.grant;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: read data is registered in the first access cycle
  assign acc_first = psel_i & penable_i & ~pready_r;
  assign xfer_done = psel_i & penable_i & pready_r;
  assign wr_en = xfer_done & pwrite_i;
  assign hit_ctrl = (paddr_i == CTRL_ADDR);
  assign hit_stat = (paddr_i == IRQ_STAT_ADDR);
  assign hit_mask = (paddr_i == IRQ_MASK_ADDR);
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_stat = wr_en & hit_stat;
  assign wr_mask = wr_en & hit_mask;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
      rd_mux = {24'h00_0000, ctrl_r & CTRL_IMPL_MASK};
    else if (hit_stat)
      rd_mux = {28'h000_0000, evt_stat_r};
    else if (hit_mask)
      rd_mux = {28'h000_0000, evt_mask_r};
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pready_r <= 1'b0;
    else
      pready_r <= acc_first;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      if (acc_first && !pwrite_i)
        prdata_r <= rd_mux;
      pslverr_r <= acc_first & ~(hit_ctrl | hit_stat | hit_mask);
    end
  end

  // ----------------------------------------------------------------
  // interrupt control register
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    // service clears first so a same-cycle new event still lands
    if (take)
    begin
      ctrl_nxt[MEN_BIT] = 1'b0;
      if (arb.grant_ext)
        ctrl_nxt[EFLAG_BIT] = 1'b0;
      else
        ctrl_nxt[TFLAG_BIT] = 1'b0;
    end
    if (return_from_irq_i)
      ctrl_nxt[MEN_BIT] = 1'b1;
    if (ext_fall)
      ctrl_nxt[EFLAG_BIT] = 1'b1;
    if (tmr_ovf_i)
      ctrl_nxt[TFLAG_BIT] = 1'b1;
    if (wr_ctrl)
      ctrl_nxt = pwdata_i[7:0];
    ctrl_nxt = ctrl_nxt & CTRL_IMPL_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_r <= CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------
  // vectored call to the core
  // ----------------------------------------------------------------
  // the call carries only a vector; the core pushes the pc and nothing else
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      call_r <= 1'b0;
      vec_r <= 8'h00;
    end
    else
    begin
      call_r <= take;
      if (take)
        vec_r <= arb.vector;
    end
  end

  // ----------------------------------------------------------------
  // halt wake-up
  // ----------------------------------------------------------------
  assign halt_entry = halted_i & ~halted_d_r;
  assign blk_now = halt_entry ? {ctrl_r[TFLAG_BIT], ctrl_r[EFLAG_BIT]} : wake_blk_r;
  assign ext_wake = halted_i & ext_fall & ~blk_now[0];
  assign tmr_wake = halted_i & tmr_ovf_i & ~blk_now[1];
  assign wake_ev = ext_wake | tmr_wake;
  assign wake_serviceable = ctrl_r[MEN_BIT] & ~stack_full &
                            (ext_wake ? ctrl_r[EEN_BIT] : ctrl_r[TEN_BIT]);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      halted_d_r <= 1'b0;
      wake_blk_r <= 2'b00;
    end
    else
    begin
      halted_d_r <= halted_i;
      if (halt_entry)
        wake_blk_r <= {ctrl_r[TFLAG_BIT], ctrl_r[EFLAG_BIT]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wake_r <= 1'b0;
      resume_next_r <= 1'b0;
    end
    else
    begin
      wake_r <= wake_ev;
      resume_next_r <= wake_ev & ~wake_serviceable;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------
  assign evt_in = {wake_ev, take, tmr_ovf_i, ext_fall};

  for (genvar i = 0; i < EVT_W; i++)
  begin : g_evt
    // a new event beats a same-cycle write-one-to-clear
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
        evt_stat_r[i] <= EVT_RESET[i];
      else if (evt_in[i])
        evt_stat_r[i] <= 1'b1;
      else if (wr_stat && pwdata_i[i])
        evt_stat_r[i] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      evt_mask_r <= MASK_RESET;
    else if (wr_mask)
      evt_mask_r <= pwdata_i[EVT_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      irq_r <= 1'b0;
    else
      irq_r <= |(evt_stat_r & evt_mask_r);
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign call_o = call_r;
  assign call_vector_o = vec_r;
  assign wake_o = wake_r;
  assign wake_resume_next_o = resume_next_r;
  assign irq_o = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_ext_call;
    take && arb.grant_ext ##1 call_r;
  endsequence

  AST_EXT_FLAG_SET: assert property (ext_fall && !wr_ctrl |=> ctrl_r[EFLAG_BIT])
    else $error("external edge did not set its flag");
  AST_TMR_FLAG_SET: assert property (tmr_ovf_i && !wr_ctrl |=> ctrl_r[TFLAG_BIT])
    else $error("timer overflow did not set its flag");
  AST_EXT_VECTOR: assert property (s_ext_call |-> vec_r == EXT_VECTOR && (!ctrl_r[MEN_BIT] ||
                                   $past(return_from_irq_i) || $past(wr_ctrl)))
    else $error("external service wrong vector or master left on");
  AST_TMR_VECTOR: assert property (take && !arb.grant_ext |=> call_r && vec_r == TMR_VECTOR)
    else $error("timer service wrong vector");
  AST_PRIORITY: assert property (take && ctrl_r[EFLAG_BIT] && ctrl_r[EEN_BIT] |=> vec_r == EXT_VECTOR)
    else $error("timer served ahead of external request");
  AST_MASTER_BLOCKS: assert property (call_r |-> $past(ctrl_r[MEN_BIT]) && $past(phase_two_pulse_i))
    else $error("call without master enable or phase pulse");
  AST_RETURN_SETS: assert property (return_from_irq_i && !wr_ctrl |=> ctrl_r[MEN_BIT])
    else $error("return from interrupt did not set master enable");
  AST_STACK_FULL: assert property (call_r |-> $past(stack_ptr_i) < STACK_FULL_LVL)
    else $error("call issued with stack full");
  AST_SOURCE_EN: assert property (call_r && vec_r == TMR_VECTOR |-> $past(ctrl_r[TEN_BIT]))
    else $error("timer served while its enable was clear");
  AST_FLAG_HOLD: assert property (ctrl_r[TFLAG_BIT] && !wr_ctrl && !(take && !arb.grant_ext) |=>
                                  ctrl_r[TFLAG_BIT])
    else $error("timer flag dropped without service or write");
  AST_UNUSED_ZERO: assert property (pready_r && hit_ctrl && !pwrite_i |->
                                    prdata_r[7:6] == 2'b00 && !prdata_r[3])
    else $error("unused control bits read nonzero");
  AST_WAKE: assert property (halted_i && halted_d_r && !wake_blk_r[0] && ext_fall |=> wake_r)
    else $error("external edge in halt did not wake");
  AST_WAKE_BLOCK: assert property (halted_i && halted_d_r && wake_blk_r[1] && tmr_ovf_i && !ext_fall |=>
                                   !wake_r)
    else $error("wake from a source already pending at halt");
  AST_RESUME: assert property (wake_ev && !ctrl_r[MEN_BIT] |=> resume_next_r && wake_r)
    else $error("disabled wake did not resume at next instruction");
  AST_WRITE_WINS: assert property (wr_ctrl |=> ctrl_r == ($past(pwdata_i[7:0]) & CTRL_IMPL_MASK))
    else $error("software write lost against hardware update");

endmodule // tsiu_top

// *** verification/tsiu_core_model.sv ***
`timescale 1ns/10ps
module tsiu_core_model
#(
  parameter int unsigned PHASE_DIV = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bench requests
  input wire logic ret_req_i,
  input wire logic halt_req_i,
  // from the interrupt unit
  input wire logic call_i,
  input wire logic wake_i,
  // to the interrupt unit
  output logic phase_two_pulse_o,
  output logic return_from_irq_o,
  output logic [2:0] stack_ptr_o,
  output logic halted_o
);
  logic [3:0] div_r;

  // ----
  // phase pulse, one cycle in every PHASE_DIV
  // ----
  always_ff @(posedge clk_i)
  begin
    if (reset_i || div_r == 4'(PHASE_DIV - 1))
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end
  assign phase_two_pulse_o = (div_r == 4'(PHASE_DIV - 1));

  // ----
  // return stack and halt state
  // ----
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      stack_ptr_o <= 3'h0;
    else if (call_i && stack_ptr_o != 3'h7)
      stack_ptr_o <= stack_ptr_o + 3'h1; // one entry: program counter only
    else if (return_from_irq_o && stack_ptr_o != 3'h0)
      stack_ptr_o <= stack_ptr_o - 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    return_from_irq_o <= !reset_i && ret_req_i;
  end

  // the core leaves halt only when woken, like the real sequencer
  always_ff @(posedge clk_i)
  begin
    if (reset_i || wake_i)
      halted_o <= 1'b0;
    else if (halt_req_i)
      halted_o <= 1'b1;
  end
endmodule // tsiu_core_model

// *** verification/two_source_interrupt_unit_tb.sv ***
`timescale 1ns/10ps
module two_source_interrupt_unit_tb;
  import tsiu_pkg::*;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_n = 1'b1;
  logic [2:0] pulse_r = 3'h0;
  logic phase;
  logic ret_pulse;
  logic halted;
  logic [2:0] stack_ptr;
  logic call;
  logic wake;
  logic resume;
  logic [7:0] vec;
  logic irq;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int n_compared = 0;

  always #2 clk_i = ~clk_i;

  tsiu_core_model core (.clk_i(clk_i), .reset_i(reset_i), .ret_req_i(pulse_r[1]), .halt_req_i(pulse_r[2]),
    .call_i(call), .wake_i(wake), .phase_two_pulse_o(phase), .return_from_irq_o(ret_pulse),
    .stack_ptr_o(stack_ptr), .halted_o(halted));

  tsiu_top uut (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_int_n_i(ext_n), .tmr_ovf_i(pulse_r[0]), .phase_two_pulse_i(phase), .return_from_irq_i(ret_pulse),
    .stack_ptr_i(stack_ptr), .halted_i(halted), .call_o(call), .call_vector_o(vec), .wake_o(wake),
    .wake_resume_next_o(resume), .irq_o(irq));

  // ----
  // reporting
  // ----
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    fail_count++;
    $display("[ERR] %s expected event seen timeout", name);
    print_verdict();
  endtask

  // ----
  // bus and stimulus
  // ----
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      timeout("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // bit 0 timer overflow, bit 1 return request, bit 2 halt request
  task automatic pulse(input int b);
    pulse_r[b] <= 1'b1;
    @(posedge clk_i);
    pulse_r <= 3'h0;
    @(posedge clk_i);
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_call(input logic [7:0] v);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (call !== 1'b1)
      timeout("call");
    chk("call_vector", vec, v);
  endtask

  task automatic wait_wake(input logic exp);
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (wake !== 1'b1)
      timeout("wake");
    chk("wake_resume_next", resume, exp);
  endtask

  // neither a call nor a wake may appear for n cycles
  task automatic quiet(input int n);
    logic [1:0] s;
    s = 2'h0;
    repeat (n)
    begin
      @(posedge clk_i);
      s = s | {call, wake};
    end
    chk("quiet", s, 32'h0);
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    do_reset();
    rdc("ctrl", CTRL_ADDR, 32'h0);
    rdc("status", IRQ_STAT_ADDR, 32'h0);
    rdc("mask", IRQ_MASK_ADDR, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    wr(CTRL_ADDR, 32'hfe);
    quiet(20);
    rdc("ctrl", CTRL_ADDR, 32'h36);
    wr(CTRL_ADDR, 32'h37);
    wait_call(EXT_VECTOR);
    rdc("ctrl", CTRL_ADDR, 32'h26);
    quiet(20);
    pulse(1);
    wait_call(TMR_VECTOR);
    rdc("ctrl", CTRL_ADDR, 32'h06);
    chk("stack_ptr", stack_ptr, 3'h1);
    rdc("status", IRQ_STAT_ADDR, 32'h4);
    chk("irq_masked", irq, 1'b0);
    wr(IRQ_MASK_ADDR, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq", irq, 1'b1);
    wr(IRQ_STAT_ADDR, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq_cleared", irq, 1'b0);
    wr(CTRL_ADDR, 32'h0);
    ext_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdc("ctrl", CTRL_ADDR, 32'h10);
    pulse(0);
    rdc("ctrl", CTRL_ADDR, 32'h30);
    rdc("status", IRQ_STAT_ADDR, 32'h3);
    wr(CTRL_ADDR, 32'h10);
    rdc("ctrl", CTRL_ADDR, 32'h10);
    do_reset();
    repeat (STACK_DEPTH)
    begin
      wr(CTRL_ADDR, 32'h25);
      wait_call(TMR_VECTOR);
    end
    wr(CTRL_ADDR, 32'h25);
    quiet(30);
    rdc("ctrl", CTRL_ADDR, 32'h25);
    pulse(1);
    wait_call(TMR_VECTOR);
    do_reset();
    pulse(2);
    pulse(0);
    wait_wake(1'b1);
    rdc("status", IRQ_STAT_ADDR, 32'ha);
    pulse(2);
    pulse(0);
    quiet(20);
    do_reset();
    wr(CTRL_ADDR, 32'h03);
    pulse(2);
    ext_n <= 1'b0;
    wait_wake(1'b0);
    ext_n <= 1'b1;
    wait_call(EXT_VECTOR);
    print_verdict();
  end
endmodule // two_source_interrupt_unit_tb
